/* core/frm_core.sv */
// fractional-n divide value composer, modulation, slip cells and ramp generator
`timescale 1ns/1ps
module frm_core (
  input wire logic clk_sys, // system clock
  input wire logic rst, // sync reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic ref_in, // reference clock pin
  input wire logic modulation_input_pin, // fsk/psk data pin
  input wire logic slip_imminent, // phase detector slip warning pin
  input wire logic freq_passed, // oscillator past target pin
  output logic [frm_pkg::ACC_W-1:0] divide_value, // integer.fraction divide
  output logic phase_invert, // psk 180 degree select
  output logic [2:0] slip_cells, // extra pump cells on
  output logic slip_dir_up, // cells source when high
  output logic pfd_tick_out // phase detector period pulse
);
  localparam int ACCW = frm_pkg::ACC_W;
  logic [31:0] r_fi, r_fl, r_rd, r_fn, r_ts, r_dl;
  logic [31:0] next_r_fi, next_r_fl, next_r_rd, next_r_fn, next_r_ts, next_r_dl;
  logic [15:0] hop_size_word [2];
  logic [15:0] next_hop0, next_hop1;
  logic [3:0] hop_size_shift [2];
  logic [3:0] next_sh0, next_sh1;
  logic [19:0] step_word [2];
  logic [19:0] next_st0, next_st1;
  logic hop_word_select;
  logic next_hsel;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [2:0] ref_s, mod_s, slip_s, pass_s;
  logic [ACCW-1:0] base_div, next_divide;
  logic pfd_tick;
  logic ref_tick;
  logic ramp_down;
  logic slip_active;
  logic [19:0] step_cnt;
  // two-stage pin synchronisers plus a third stage for edges
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ref_s <= 3'h0;
      mod_s <= 3'h0;
      slip_s <= 3'h0;
      pass_s <= 3'h0;
    end else begin
      ref_s <= {ref_s[1:0], ref_in};
      mod_s <= {mod_s[1:0], modulation_input_pin};
      slip_s <= {slip_s[1:0], slip_imminent};
      pass_s <= {pass_s[1:0], freq_passed};
    end
  end
  function automatic logic rise(input logic [2:0] s);
    return s[1] & ~s[2];
  endfunction
  // synchronised reference edge into the divider
  assign ref_tick = rise(ref_s);
  frm_pfd_gen u_pfd (
    .clk_sys(clk_sys),
    .rst(rst),
    .ref_tick(ref_tick),
    .doubler(r_rd[frm_pkg::DBL_BIT]),
    .half(r_rd[frm_pkg::HALF_BIT]),
    .rdiv(r_rd[frm_pkg::RDIV_LSB +: frm_pkg::RDIV_W]),
    .pfd_tick(pfd_tick)
  );
  // register file
  // no wait states: ready rises the cycle after setup
  logic wr_en;
  assign wr_en = psel & penable & pwrite & pready;
  always_comb begin
    next_r_fi = r_fi;
    next_r_fl = r_fl;
    next_r_rd = r_rd;
    next_r_fn = r_fn;
    next_r_ts = r_ts;
    next_r_dl = r_dl;
    next_hop0 = hop_size_word[0];
    next_hop1 = hop_size_word[1];
    next_sh0 = hop_size_shift[0];
    next_sh1 = hop_size_shift[1];
    next_st0 = step_word[0];
    next_st1 = step_word[1];
    next_hsel = hop_word_select;
    next_pready = psel & ~pready;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (psel && !pready) begin
      case (paddr)
        frm_pkg::ADDR_FRAC_INT: next_prdata = r_fi;
        frm_pkg::ADDR_FRAC_LOW: next_prdata = r_fl;
        frm_pkg::ADDR_REF_DIV: next_prdata = r_rd;
        frm_pkg::ADDR_FUNCTION: next_prdata = r_fn;
        frm_pkg::ADDR_TEST: next_prdata = r_ts;
        frm_pkg::ADDR_DEVIATION: next_prdata = {8'h00, hop_word_select,
          hop_size_shift[hop_word_select], hop_size_word[hop_word_select], 3'h0};
        frm_pkg::ADDR_STEP: next_prdata = {12'h000, step_word[0]};
        frm_pkg::ADDR_DELAY: next_prdata = r_dl;
        frm_pkg::ADDR_STATUS: next_prdata = {24'h000000, ramp_down, slip_active,
          mod_s[1], 2'h0, slip_cells};
        frm_pkg::ADDR_DIVIDE: next_prdata = divide_value[ACCW-1:5];
        frm_pkg::ADDR_PFD_CTRL: next_prdata = {12'h000, step_cnt};
        default: next_pslverr = 1'b1;
      endcase
    end
    if (wr_en) begin
      case (paddr)
        frm_pkg::ADDR_FRAC_INT: next_r_fi = pwdata;
        frm_pkg::ADDR_FRAC_LOW: next_r_fl = pwdata;
        frm_pkg::ADDR_REF_DIV: next_r_rd = pwdata;
        frm_pkg::ADDR_FUNCTION: next_r_fn = pwdata;
        frm_pkg::ADDR_TEST: next_r_ts = pwdata;
        frm_pkg::ADDR_DELAY: next_r_dl = pwdata;
        frm_pkg::ADDR_DEVIATION: begin
          next_hsel = pwdata[frm_pkg::HSEL_BIT];
          if (pwdata[frm_pkg::HSEL_BIT]) begin
            next_hop1 = pwdata[frm_pkg::HOP_LSB +: frm_pkg::HOP_W];
            next_sh1 = pwdata[frm_pkg::SHIFT_LSB +: frm_pkg::SHIFT_W];
          end else begin
            next_hop0 = pwdata[frm_pkg::HOP_LSB +: frm_pkg::HOP_W];
            next_sh0 = pwdata[frm_pkg::SHIFT_LSB +: frm_pkg::SHIFT_W];
          end
        end
        frm_pkg::ADDR_STEP: begin
          if (pwdata[frm_pkg::SSEL_BIT]) begin
            next_st1 = pwdata[frm_pkg::STEP_LSB +: frm_pkg::STEP_W];
          end else begin
            next_st0 = pwdata[frm_pkg::STEP_LSB +: frm_pkg::STEP_W];
          end
        end
        // read-only and unmapped words drop writes, error decided in setup for unmapped words only
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r_fi <= frm_pkg::REG_RESET;
      r_fl <= frm_pkg::REG_RESET;
      r_rd <= frm_pkg::REG_RESET;
      r_fn <= frm_pkg::REG_RESET;
      r_ts <= frm_pkg::REG_RESET;
      r_dl <= frm_pkg::REG_RESET;
      hop_size_word[0] <= 16'h0000;
      hop_size_word[1] <= 16'h0000;
      hop_size_shift[0] <= 4'h0;
      hop_size_shift[1] <= 4'h0;
      step_word[0] <= 20'h00000;
      step_word[1] <= 20'h00000;
      hop_word_select <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      r_fi <= next_r_fi;
      r_fl <= next_r_fl;
      r_rd <= next_r_rd;
      r_fn <= next_r_fn;
      r_ts <= next_r_ts;
      r_dl <= next_r_dl;
      hop_size_word[0] <= next_hop0;
      hop_size_word[1] <= next_hop1;
      hop_size_shift[0] <= next_sh0;
      hop_size_shift[1] <= next_sh1;
      step_word[0] <= next_st0;
      step_word[1] <= next_st1;
      hop_word_select <= next_hsel;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr & psel;
    end
  end
  // scaled hop word, signed, sign-extended to accumulator width
  function automatic logic [ACCW-1:0] scaled(input logic [15:0] w, input logic [3:0] s);
    logic [ACCW-1:0] ext;
    ext = {{(ACCW-16){w[15]}}, w};
    return ext << s;
  endfunction
  // base divide: whole<<25 + (upper<<13) + lower
  always_comb begin
    base_div = ({{(ACCW-frm_pkg::INT_W){1'b0}}, r_fi[frm_pkg::INT_LSB +: frm_pkg::INT_W]}
      << frm_pkg::FRAC_W)
      + ({{(ACCW-frm_pkg::FMSB_W){1'b0}}, r_fi[frm_pkg::FMSB_LSB +: frm_pkg::FMSB_W]}
      << frm_pkg::FLSB_W)
      + {{(ACCW-frm_pkg::FLSB_W){1'b0}}, r_fl[frm_pkg::FLSB_LSB +: frm_pkg::FLSB_W]};
  end
  // ramp generator
  // hop timer and step counter advance on pfd ticks only
  logic ramp_on, next_ramp_down, ramp_done, next_ramp_done;
  logic [23:0] tmr, next_tmr;
  logic [19:0] next_step_cnt;
  logic [ACCW-1:0] ramp_off, next_ramp_off;
  logic [23:0] interval;
  frm_pkg::frm_mode_type mode;
  assign ramp_on = r_fi[frm_pkg::RAMP_ON_BIT];
  assign mode = frm_pkg::frm_mode_type'(r_fn[frm_pkg::MODE_LSB +: 2]);
  assign interval = 24'(r_rd[frm_pkg::DIVA_LSB +: frm_pkg::DIV_W])
    * 24'(r_ts[frm_pkg::DIVB_LSB +: frm_pkg::DIV_W]);
  always_comb begin
    next_tmr = tmr;
    next_step_cnt = step_cnt;
    next_ramp_off = ramp_off;
    next_ramp_down = ramp_down;
    next_ramp_done = ramp_done;
    if (!ramp_on) begin
      next_tmr = 24'h000000;
      next_step_cnt = 20'h00000;
      next_ramp_off = '0;
      next_ramp_down = 1'b0;
      next_ramp_done = 1'b0;
    end else if (pfd_tick) begin
      if (tmr + 24'h000001 >= interval) begin
        next_tmr = 24'h000000;
        if (!ramp_done) begin
          if (step_cnt < step_word[0]) begin
            next_step_cnt = step_cnt + 20'h00001;
            if (ramp_down) begin
              next_ramp_off = ramp_off - scaled(hop_size_word[0], hop_size_shift[0]);
            end else begin
              next_ramp_off = ramp_off + scaled(hop_size_word[0], hop_size_shift[0]);
            end
          end else begin
            next_step_cnt = 20'h00000;
            // a triangle turn holds its value for one interval
            case (mode)
              frm_pkg::RAMP_BURST: next_ramp_done = 1'b1;
              frm_pkg::RAMP_SAW_BURST: begin
                next_ramp_off = '0;
                next_ramp_done = 1'b1;
              end
              frm_pkg::RAMP_SAW: next_ramp_off = '0;
              frm_pkg::RAMP_TRI: next_ramp_down = ~ramp_down;
              default: next_ramp_done = 1'b1;
            endcase
          end
        end
      end else begin
        next_tmr = tmr + 24'h000001;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tmr <= 24'h000000;
      step_cnt <= 20'h00000;
      ramp_off <= '0;
      ramp_down <= 1'b0;
      ramp_done <= 1'b0;
    end else begin
      tmr <= next_tmr;
      step_cnt <= next_step_cnt;
      ramp_off <= next_ramp_off;
      ramp_down <= next_ramp_down;
      ramp_done <= next_ramp_done;
    end
  end
  // fsk and psk from the modulation pin
  // fsk deviation rides on top of the ramp offset
  logic fsk_en, psk_en, next_phase;
  assign fsk_en = r_fn[frm_pkg::FSK_BIT];
  assign psk_en = r_fn[frm_pkg::PSK_BIT];
  always_comb begin
    next_divide = base_div + ramp_off;
    if (fsk_en) begin
      if (mod_s[1]) begin
        next_divide = next_divide + scaled(hop_size_word[1], hop_size_shift[1]);
      end else begin
        next_divide = next_divide - scaled(hop_size_word[1], hop_size_shift[1]);
      end
    end
    next_phase = psk_en & mod_s[1];
  end
  // slip reduction cells
  logic releasing, next_releasing;
  logic [2:0] next_cells;
  assign slip_active = r_rd[frm_pkg::SLIP_EN_BIT];
  // a pass edge outranks a slip edge in the same cycle
  always_comb begin
    next_cells = slip_cells;
    next_releasing = releasing;
    if (!slip_active) begin
      next_cells = 3'h0;
      next_releasing = 1'b0;
    end else if (rise(pass_s)) begin
      next_releasing = 1'b1;
    end else if (releasing && pfd_tick) begin
      if (slip_cells != 3'h0) begin
        next_cells = slip_cells - 3'h1;
      end else begin
        next_releasing = 1'b0;
      end
    end else if (!releasing && rise(slip_s) && slip_cells < 3'(frm_pkg::SLIP_MAX)) begin
      next_cells = slip_cells + 3'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divide_value <= '0;
      phase_invert <= 1'b0;
      slip_cells <= 3'h0;
      releasing <= 1'b0;
      slip_dir_up <= 1'b0;
      pfd_tick_out <= 1'b0;
    end else begin
      divide_value <= next_divide;
      phase_invert <= next_phase;
      slip_cells <= next_cells;
      releasing <= next_releasing;
      slip_dir_up <= ~pass_s[1];
      pfd_tick_out <= pfd_tick;
    end
  end
endmodule

/* core/frm_pkg.sv */
// constants for the fractional-n ramp modulator core
package frm_pkg;
  // apb word addresses
  localparam logic [7:0] ADDR_FRAC_INT = 8'h00;
  localparam logic [7:0] ADDR_FRAC_LOW = 8'h04;
  localparam logic [7:0] ADDR_REF_DIV = 8'h08;
  localparam logic [7:0] ADDR_FUNCTION = 8'h0C;
  localparam logic [7:0] ADDR_TEST = 8'h10;
  localparam logic [7:0] ADDR_DEVIATION = 8'h14;
  localparam logic [7:0] ADDR_STEP = 8'h18;
  localparam logic [7:0] ADDR_DELAY = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_DIVIDE = 8'h24;
  localparam logic [7:0] ADDR_PFD_CTRL = 8'h28;
  // fraction/integer register fields
  localparam int RAMP_ON_BIT = 31;
  localparam int INT_LSB = 15;
  localparam int INT_W = 12;
  localparam int FMSB_LSB = 3;
  localparam int FMSB_W = 12;
  // low fraction register
  localparam int FLSB_LSB = 15;
  localparam int FLSB_W = 13;
  localparam int FRAC_W = 25;
  // reference-divider register
  localparam int SLIP_EN_BIT = 28;
  localparam int DBL_BIT = 20;
  localparam int HALF_BIT = 21;
  localparam int RDIV_LSB = 15;
  localparam int RDIV_W = 5;
  localparam int DIVA_LSB = 3;
  localparam int DIV_W = 12;
  // function register
  localparam int MODE_LSB = 10;
  localparam int PSK_BIT = 9;
  localparam int FSK_BIT = 8;
  localparam int POL_BIT = 6;
  // test register
  localparam int DIVB_LSB = 7;
  // deviation register
  localparam int HSEL_BIT = 23;
  localparam int SHIFT_LSB = 19;
  localparam int SHIFT_W = 4;
  localparam int HOP_LSB = 3;
  localparam int HOP_W = 16;
  // step register
  localparam int SSEL_BIT = 23;
  localparam int STEP_LSB = 3;
  localparam int STEP_W = 20;
  // divide accumulator: integer + fraction
  localparam int ACC_W = 37;
  localparam int SLIP_MAX = 7;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {
    RAMP_BURST,
    RAMP_SAW_BURST,
    RAMP_SAW,
    RAMP_TRI
  } frm_mode_type;
endpackage

/* core/frm_pfd_gen.sv */
// reference path divider producing the phase detector clock enable
`timescale 1ns/1ps
module frm_pfd_gen (
  input wire logic clk_sys, // system clock
  input wire logic rst, // sync reset
  input wire logic ref_tick, // synchronised reference edge pulse
  input wire logic doubler, // double reference rate
  input wire logic half, // extra divide by two
  input wire logic [4:0] rdiv, // reference divide factor
  output logic pfd_tick // one pulse per phase detector period
);
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic tog;
  logic next_tog;
  logic next_pfd_tick;
  logic [5:0] limit;
  // doubler counts each tick twice, half doubles the count
  always_comb begin
    limit = (rdiv == 5'h00) ? 6'h01 : {1'b0, rdiv};
    next_cnt = cnt;
    next_tog = tog;
    next_pfd_tick = 1'b0;
    if (ref_tick) begin
      if (cnt + 6'h01 >= limit) begin
        next_cnt = 6'h00;
        next_tog = ~tog;
        next_pfd_tick = half ? tog : 1'b1;
      end else begin
        next_cnt = cnt + (doubler ? 6'h02 : 6'h01);
        if (doubler && next_cnt >= limit) begin
          next_cnt = 6'h00;
          next_tog = ~tog;
          next_pfd_tick = half ? tog : 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt <= 6'h00;
      tog <= 1'b0;
      pfd_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tog <= next_tog;
      pfd_tick <= next_pfd_tick;
    end
  end
endmodule

/* sim/frm_core_chk.sv */
// port-level assertion checker for the ramp modulator core
`timescale 1ns/1ps
module frm_core_chk (
  input wire logic clk_sys, // clock
  input wire logic rst, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic slip_imminent, // slip pin
  input wire logic [36:0] divide_value, // divide
  input wire logic phase_invert, // psk select
  input wire logic [2:0] slip_cells, // cells on
  input wire logic slip_dir_up, // direction
  input wire logic pfd_tick_out // pfd pulse
);
  logic [2:0] since_slip;
  logic [2:0] next_since_slip;
  // cycles since the slip pin was last high, saturating
  always_comb begin
    next_since_slip = since_slip;
    if (rst || slip_imminent) next_since_slip = 3'h0;
    else if (since_slip != 3'h7) next_since_slip = since_slip + 3'h1;
  end
  always_ff @(posedge clk_sys) begin
    since_slip <= next_since_slip;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  reset_zero_a: assert property ($past(rst) |-> divide_value == 37'h0 && slip_cells == 3'h0
    && !phase_invert && !pready) else $error("outputs not clear after reset");
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside access or too long");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response without ready or with data");
  unmapped_err_a: assert property (psel && !penable && !pready
    && paddr > frm_pkg::ADDR_PFD_CTRL |=> pslverr) else $error("no error for unmapped address");
  cell_step_a: assert property ($changed(slip_cells) |->
    ({1'b0, slip_cells} == {1'b0, $past(slip_cells)} + 4'h1) ||
    ({1'b0, $past(slip_cells)} == {1'b0, slip_cells} + 4'h1)) else $error("cells jumped");
  cell_rise_a: assert property (slip_cells > $past(slip_cells) |->
    since_slip < 3'h7 && slip_dir_up) else $error("cell added without slip warning");
  cell_fall_a: assert property (slip_cells < $past(slip_cells) |-> !slip_dir_up)
    else $error("cell released before target passed");
  pfd_pulse_a: assert property (pfd_tick_out |=> !pfd_tick_out)
    else $error("pfd tick longer than one cycle");
  cover property (slip_cells == 3'h7);
  cover property (pslverr);
  cover property (phase_invert);
endmodule

/* sim/frm_host_model.sv */
// host-side pin model: reference clock, slip pins and data pin
`timescale 1ns/1ps
module frm_host_model (
  input wire logic clk_sys, // clock
  output logic ref_in, // reference
  output logic slip_imminent, // slip warning
  output logic freq_passed, // past target
  output logic modulation_input_pin // data pin
);
  logic [1:0] ref_cnt;
  initial begin
    ref_in = 1'b0;
    ref_cnt = 2'h0;
    slip_imminent = 1'b0;
    freq_passed = 1'b0;
    modulation_input_pin = 1'b0;
  end
  // 5 MHz square reference, even duty
  always @(posedge clk_sys) begin
    ref_cnt <= ref_cnt + 2'h1;
    if (ref_cnt == 2'h3) ref_in <= !ref_in;
  end
  task automatic slip_pulse();
    slip_imminent <= 1'b1;
    repeat (3) @(posedge clk_sys);
    slip_imminent <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic set_pins(input logic passed, input logic data);
    freq_passed <= passed;
    modulation_input_pin <= data;
  endtask
endmodule

/* sim/testbench.sv */
// self-checking bench for the ramp modulator core
`timescale 1ns/1ps
bind frm_core frm_core_chk frm_core_chk_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .slip_imminent(slip_imminent), .divide_value(divide_value), .phase_invert(phase_invert),
  .slip_cells(slip_cells), .slip_dir_up(slip_dir_up), .pfd_tick_out(pfd_tick_out));
module testbench;
  localparam logic [36:0] BASE = 37'h00C80A3D71;
  localparam logic [36:0] D = 37'h40;
  localparam logic [36:0] F = 37'h60;
  localparam int NCHG [4] = '{3, 4, 8, 8};
  localparam int SEQ [4][8] = '{'{1, 2, 3, 0, 0, 0, 0, 0}, '{1, 2, 3, 0, 0, 0, 0, 0},
    '{1, 2, 3, 0, 1, 2, 3, 0}, '{1, 2, 3, 2, 1, 0, 1, 2}};
  localparam logic [31:0] RDW [4] = '{32'h0001_8010, 32'h0021_0010, 32'h0011_0010,
    32'h0001_0010};
  localparam int GAP [4] = '{24, 32, 8, 16};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ref_in, modulation_input_pin, slip_imminent, freq_passed;
  logic phase_invert, slip_dir_up, pfd_tick_out;
  logic [36:0] divide_value;
  logic [2:0] slip_cells;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [36:0] last_dv = 37'h0;
  logic [36:0] chg_q [$];
  int chg_t [$];
  frm_core frm_core_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_in(ref_in), .modulation_input_pin(modulation_input_pin),
    .slip_imminent(slip_imminent), .freq_passed(freq_passed), .divide_value(divide_value),
    .phase_invert(phase_invert), .slip_cells(slip_cells), .slip_dir_up(slip_dir_up),
    .pfd_tick_out(pfd_tick_out));
  frm_host_model frm_host_model_inst (.clk_sys(clk_sys), .ref_in(ref_in),
    .slip_imminent(slip_imminent), .freq_passed(freq_passed),
    .modulation_input_pin(modulation_input_pin));
  initial forever #12.5 clk_sys = ~clk_sys;
  // log every change of the divide value with its cycle
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    last_dv <= divide_value;
    if (!rst && divide_value !== last_dv) begin
      chg_q.push_back(divide_value);
      chg_t.push_back(cyc);
    end
  end
  task automatic end_sim();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic timeout_fail();
    n_errors++;
    end_sim();
  endtask
  task automatic chk(input logic [36:0] got, input logic [36:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) timeout_fail();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(a, 1'b1, d, q, e);
  endtask
  task automatic tick_gap(output int g);
    for (int k = 0; k < 3; k++) begin
      g = 1;
      @(posedge clk_sys);
      while (pfd_tick_out !== 1'b1 && g < 99) begin
        @(posedge clk_sys);
        g++;
      end
      if (g >= 99) timeout_fail();
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    timeout_fail();
  end
  initial begin
    logic [31:0] q;
    logic e;
    int g;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    wr(frm_pkg::ADDR_DELAY, 32'h0);
    wr(frm_pkg::ADDR_STEP, 32'h0000_0018);
    wr(frm_pkg::ADDR_STEP, 32'h0080_0028);
    wr(frm_pkg::ADDR_DEVIATION, 32'h0010_0080);
    wr(frm_pkg::ADDR_DEVIATION, 32'h0088_0180);
    wr(frm_pkg::ADDR_TEST, 32'h0000_0080);
    wr(frm_pkg::ADDR_FUNCTION, 32'h0000_0040);
    wr(frm_pkg::ADDR_REF_DIV, 32'h0001_0010);
    wr(frm_pkg::ADDR_FRAC_LOW, 32'h0EB8_8000);
    wr(frm_pkg::ADDR_FRAC_INT, 32'h0032_0288);
    repeat (5) @(posedge clk_sys);
    chk(divide_value, BASE);
    apb(frm_pkg::ADDR_DIVIDE, 1'b0, 32'h0, q, e);
    chk(37'(q), 37'(BASE[36:5]));
    apb(8'h40, 1'b0, 32'h0, q, e);
    chk(37'(e), 37'h1);
    chk(37'(q), 37'h0);
    for (int r = 0; r < 4; r++) begin
      wr(frm_pkg::ADDR_REF_DIV, RDW[r]);
      tick_gap(g);
      chk(37'(g), 37'(GAP[r]));
    end
    for (int m = 0; m < 4; m++) begin
      wr(frm_pkg::ADDR_FRAC_INT, 32'h0032_0288);
      wr(frm_pkg::ADDR_FUNCTION, 32'h40 | (m << 10));
      repeat (5) @(posedge clk_sys);
      chg_q.delete();
      chg_t.delete();
      wr(frm_pkg::ADDR_FRAC_INT, 32'h8032_0288);
      repeat (420) @(posedge clk_sys);
      chk(37'(chg_q.size() > 7 ? 8 : chg_q.size()), 37'(NCHG[m]));
      for (int k = 0; k < NCHG[m] && k < chg_q.size(); k++)
        chk(chg_q[k], BASE + D * SEQ[m][k]);
      chk(37'(chg_t[1] - chg_t[0]), 37'h20);
    end
    wr(frm_pkg::ADDR_FRAC_INT, 32'h0032_0288);
    wr(frm_pkg::ADDR_FUNCTION, 32'h0000_0140);
    for (int v = 0; v < 2; v++) begin
      frm_host_model_inst.set_pins(1'b0, !v[0]);
      repeat (10) @(posedge clk_sys);
      chk(divide_value, v == 0 ? BASE + F : BASE - F);
    end
    wr(frm_pkg::ADDR_FUNCTION, 32'h0000_0240);
    for (int v = 0; v < 2; v++) begin
      frm_host_model_inst.set_pins(1'b0, v[0]);
      repeat (10) @(posedge clk_sys);
      chk(37'(phase_invert), 37'(v));
    end
    wr(frm_pkg::ADDR_FUNCTION, 32'h0000_0040);
    repeat (2) frm_host_model_inst.slip_pulse();
    chk(37'(slip_cells), 37'h0);
    wr(frm_pkg::ADDR_REF_DIV, 32'h1001_0010);
    repeat (9) frm_host_model_inst.slip_pulse();
    chk(37'(slip_cells), 37'h7);
    chk(37'(slip_dir_up), 37'h1);
    frm_host_model_inst.set_pins(1'b1, 1'b0);
    repeat (200) @(posedge clk_sys);
    chk(37'(slip_cells), 37'h0);
    chk(37'(slip_dir_up), 37'h0);
    end_sim();
  end
endmodule
